// ### core/power_quality_monitor.sv
/*
  Power-quality monitor: integrator enable, zero crossing and timeout,
  period or frequency, sag and peak detection with read-clear records.
  All state runs on clk; slower rates are one-cycle enables from dividers.
  Status flags clear by writing zero; a same-cycle hardware set wins.
  Interrupt outputs follow status and enables one clock later.

  Assumes samples come from logic on clk and a single-cycle register port.
  Read data stands for the one cycle after the read strobe, zero otherwise.
  The master never raises both strobes at once and is never held off.
  Peak levels compare against sample magnitude bits 23:8, the sag level against those of the crossing input.
*/
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module power_quality_monitor
  import pqm_pkg::*;
#(
  // Numerator that turns period counts into frequency steps
  parameter int unsigned FREQ_NUM = 32'd6553600  // freq LSB numerator
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire sample_t     smp,
  input  wire reg_req_t    req,
  output logic      [23:0] rdata,
  output logic             integ_en,
  output logic             ade_irq,
  output logic             psm_irq,
  output logic             zx_pulse
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Absolute value; the most negative code wraps to itself
  function automatic logic [23:0] mag24(input logic [23:0] s);
    mag24 = s[23] ? 24'(-s) : s;
  endfunction

  // Magnitude bits 23:8 strictly above a 16-bit level
  function automatic logic over_level(input logic [23:0] m,
                                      input logic [15:0] lvl);
    over_level = m[23:8] > lvl;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Software-visible configuration
  logic [7:0]         mode_one_r;    // integrator, filter bypass
  logic [7:0]         mode_two_r;    // period or frequency select
  logic [7:0]         sag_cyc_r;     // cycles below level, plus one
  logic [11:0]        zx_load_r;     // timeout reload value
  logic [15:0]        sag_lvl_r;     // sag level
  logic [15:0]        ipk_lvl_r;     // current peak level
  logic [15:0]        vpk_lvl_r;     // voltage peak level
  logic [7:0]         irq_en_r;      // upper interrupt enables
  logic [7:0]         psm_en_r;      // supply interrupt enables
  // Hardware-owned state
  logic [11:0]        zx_cnt_r;      // timeout down-counter
  logic [15:0]        line_period_or_frequency_r;    // period or frequency result
  logic [23:0]        ipk_rec_r;     // current peak record
  logic [23:0]        vpk_rec_r;     // voltage peak record
  logic [7:0]         irq_st_r;      // upper interrupt status
  logic [7:0]         psm_fl_r;      // supply interrupt flags
  logic [7:0]         div160_r;      // timeout step divider
  logic [3:0]         div10_r;       // period step divider
  logic [15:0]        per_cnt_r;     // period counter
  logic [7:0]         sag_run_r;     // full cycles spent below
  logic signed [23:0] lpf_r;         // line filter state
  logic               sign_r;        // last crossing-input sign
  logic               below_r;       // below level since crossing

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // One strobe per writable address, two read-clear strobes
  // Read-clear acts on the read edge, after the mux took the value
  wire wr_measurement_mode_one = req.wr && req.addr == ADDR_MODE_ONE;
  wire wr_measurement_mode_two = req.wr && req.addr == ADDR_MODE_TWO;
  wire wr_crossing_timeout_flag  = req.wr && req.addr == ADDR_ZX_TIMEOUT;
  wire wr_sagc  = req.wr && req.addr == ADDR_SAG_CYC;
  wire wr_sagl  = req.wr && req.addr == ADDR_SAG_LVL;
  wire wr_ipkl  = req.wr && req.addr == ADDR_IPK_LVL;
  wire wr_vpkl  = req.wr && req.addr == ADDR_VPK_LVL;
  wire wr_irqe  = req.wr && req.addr == ADDR_IRQ_EN_HI;
  wire wr_irqs  = req.wr && req.addr == ADDR_IRQ_ST_HI;
  wire wr_psme  = req.wr && req.addr == ADDR_PSM_EN;
  wire wr_psmf  = req.wr && req.addr == ADDR_PSM_FLAGS;
  wire rc_ipk   = req.rd && req.addr == ADDR_IPK_RC;
  wire rc_vpk   = req.rd && req.addr == ADDR_VPK_RC;

  // ---------------------------------------------------------------
  // Signal path
  // ---------------------------------------------------------------
  // Single-pole line filter, or bypass, feeds crossing and sag
  wire signed [23:0] v_s     = smp.volt;
  wire signed [23:0] lpf_nxt = lpf_r + ((v_s - lpf_r) >>> LPF_SHIFT);
  wire signed [23:0] zx_in   = mode_one_r[BIT_LPF_BYP] ? v_s : lpf_r;
  wire [23:0] zx_mag  = mag24(zx_in);
  wire [23:0] v_mag   = mag24(smp.volt);
  wire [23:0] i_mag   = mag24(smp.curr);

  // Crossing is a sign change of the crossing input per sample
  wire        zx_evt  = smp.valid && (zx_in[23] != sign_r);
  wire        rising  = zx_evt && !zx_in[23];                          // full cycle

  // ---------------------------------------------------------------
  // Divider ticks and timeout expiry
  // ---------------------------------------------------------------
  wire        tick160 = div160_r == 8'(CROSSING_TIMEOUT_FLAG_DIV - 1);
  wire        tick10  = div10_r == 4'(PER_DIV - 1);
  wire        zx_expire = tick160 && zx_cnt_r == 12'h001;
  // Reload on a crossing or on expiry, else step down
  wire        zx_reload = zx_evt || zx_expire;
  wire        zx_step   = tick160 && zx_cnt_r != 12'h000;

  // ---------------------------------------------------------------
  // Level comparisons and measurement terms
  // ---------------------------------------------------------------
  // Level 0x00 and 0x01 both mean zero
  wire [15:0] sag_eff = (sag_lvl_r <= 16'h0001) ? 16'h0000 : sag_lvl_r;
  wire        v_below = zx_mag[23:8] < sag_eff;
  wire        pkv_hit = smp.valid &&
                        over_level(v_mag, vpk_lvl_r);
  wire        pki_hit = smp.valid &&
                        over_level(i_mag, ipk_lvl_r);
  // Sag declared on the rising crossing that closes the run
  wire        sag_hit = rising && below_r &&
                        sag_cyc_r > 8'h01 &&
                        sag_run_r + 8'h01 == sag_cyc_r - 8'h01;
  // Frequency is a fixed numerator over the period count
  wire [15:0] freq_val = (per_cnt_r == 16'h0000) ? 16'h0000 :
                         16'(FREQ_NUM / {16'h0000, per_cnt_r});
  // Period counter saturates rather than wrapping
  wire        per_step = tick10 && per_cnt_r != 16'hffff;

  // ---------------------------------------------------------------
  // Next values of status flags and peak records
  // ---------------------------------------------------------------
  // Status set terms, set beats clear
  wire [7:0] st_set = {3'b000, pki_hit, pkv_hit, 1'b0, zx_expire, zx_evt};
  wire [7:0] irq_st_keep = wr_irqs ? (irq_st_r & req.wdata[7:0]) : irq_st_r;
  wire [7:0] irq_st_nxt  = irq_st_keep | st_set;
  wire [7:0] psm_fl_keep = wr_psmf ? (psm_fl_r & req.wdata[7:0]) : psm_fl_r;
  wire [7:0] psm_fl_nxt  = psm_fl_keep | (8'(sag_hit) << BIT_SAG);
  // Records take a larger magnitude; read-clear wins
  wire        ipk_grow    = smp.valid && i_mag > ipk_rec_r;
  wire        vpk_grow    = smp.valid && v_mag > vpk_rec_r;
  wire [23:0] ipk_rec_nxt = rc_ipk   ? 24'h000000 :
                            ipk_grow ? i_mag : ipk_rec_r;
  wire [23:0] vpk_rec_nxt = rc_vpk   ? 24'h000000 :
                            vpk_grow ? v_mag : vpk_rec_r;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Reset values, then single-cycle writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_one_r <= 8'h00;
      mode_two_r <= 8'h00;
      zx_load_r  <= ZX_TIMEOUT_RST;
      sag_cyc_r  <= SAG_CYC_RST;
      sag_lvl_r  <= SAG_LVL_RST;
      ipk_lvl_r  <= PK_LVL_RST;
      vpk_lvl_r  <= PK_LVL_RST;
      irq_en_r   <= 8'h00;
      psm_en_r   <= 8'h00;
    end else begin
      if (wr_measurement_mode_one) mode_one_r <= req.wdata[7:0];
      if (wr_measurement_mode_two) mode_two_r <= req.wdata[7:0];
      if (wr_crossing_timeout_flag)  zx_load_r  <= req.wdata[11:0];
      if (wr_sagc)  sag_cyc_r  <= req.wdata[7:0];
      if (wr_sagl)  sag_lvl_r  <= req.wdata[15:0];
      if (wr_ipkl)  ipk_lvl_r  <= req.wdata[15:0];
      if (wr_vpkl)  vpk_lvl_r  <= req.wdata[15:0];
      if (wr_irqe)  irq_en_r   <= req.wdata[7:0];
      if (wr_psme)  psm_en_r   <= req.wdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Status flags: write 0 to clear, hardware set wins
  // ---------------------------------------------------------------
  // Flags hold until software writes zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_st_r <= 8'h00;
      psm_fl_r <= 8'h00;
    end else begin
      irq_st_r <= irq_st_nxt;
      psm_fl_r <= psm_fl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Filter, crossing tracker, dividers
  // ---------------------------------------------------------------
  // Filter and sign move only on samples; dividers run free
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lpf_r    <= '0;
      sign_r   <= 1'b0;
      div160_r <= 8'h00;
      div10_r  <= 4'h0;
    end else begin
      if (smp.valid) lpf_r <= lpf_nxt;
      if (smp.valid) sign_r <= zx_in[23];
      div160_r <= tick160 ? 8'h00 : div160_r + 8'h01;
      div10_r  <= tick10 ? 4'h0 : div10_r + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Timeout counter, reloaded on each crossing
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      zx_cnt_r <= ZX_TIMEOUT_RST;
    end else if (zx_reload) begin
      zx_cnt_r <= zx_load_r;
    end else if (zx_step) begin
      zx_cnt_r <= zx_cnt_r - 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // Period or frequency, updated each rising crossing
  // ---------------------------------------------------------------
  // Latch the count or its reciprocal, then restart
  always_ff @(posedge clk) begin
    if (!rstn) begin
      per_cnt_r  <= 16'h0000;
      line_period_or_frequency_r <= 16'h0000;
    end else if (rising) begin
      per_cnt_r  <= 16'h0000;
      line_period_or_frequency_r <= mode_two_r[BIT_FREQ_SEL] ? freq_val : per_cnt_r;
    end else if (per_step) begin
      per_cnt_r  <= per_cnt_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Sag: count full cycles spent below the level
  // ---------------------------------------------------------------
  // Any sample not below the level breaks the run, except one on a rising crossing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      below_r   <= 1'b0;
      sag_run_r <= 8'h00;
    end else if (rising) begin
      below_r   <= 1'b1;
      sag_run_r <= below_r ? sag_run_r + 8'h01 : 8'h00;
    end else if (smp.valid && !v_below) begin
      below_r   <= 1'b0;
      sag_run_r <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Peak records, read-clear wins
  // ---------------------------------------------------------------
  // Both records follow their next values every cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ipk_rec_r <= 24'h000000;
      vpk_rec_r <= 24'h000000;
    end else begin
      ipk_rec_r <= ipk_rec_nxt;
      vpk_rec_r <= vpk_rec_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read mux and outputs
  // ---------------------------------------------------------------
  // Zero-extended read views of each readable register narrower than 24 bits
  wire [23:0] rv_line_period_or_frequency = {8'h00, line_period_or_frequency_r};
  wire [23:0] rv_mode_one = {16'h0000, mode_one_r};
  wire [23:0] rv_mode_two = {16'h0000, mode_two_r};
  wire [23:0] rv_zx_load  = {12'h000, zx_load_r};
  wire [23:0] rv_sag_cyc  = {16'h0000, sag_cyc_r};
  wire [23:0] rv_sag_lvl  = {8'h00, sag_lvl_r};
  wire [23:0] rv_ipk_lvl  = {8'h00, ipk_lvl_r};
  wire [23:0] rv_vpk_lvl  = {8'h00, vpk_lvl_r};
  wire [23:0] rv_irq_en   = {16'h0000, irq_en_r};
  wire [23:0] rv_irq_st   = {16'h0000, irq_st_r};
  wire [23:0] rv_psm_en   = {16'h0000, psm_en_r};
  wire [23:0] rv_psm_fl   = {16'h0000, psm_fl_r};

  // Address select; unmapped offsets read as zero
  logic [23:0] rd_mux;
  always_comb begin
    if (req.addr == ADDR_LINE_PERIOD_OR_FREQUENCY)        rd_mux = rv_line_period_or_frequency;
    else if (req.addr == ADDR_MODE_ONE)   rd_mux = rv_mode_one;
    else if (req.addr == ADDR_MODE_TWO)   rd_mux = rv_mode_two;
    else if (req.addr == ADDR_ZX_TIMEOUT) rd_mux = rv_zx_load;
    else if (req.addr == ADDR_SAG_CYC)    rd_mux = rv_sag_cyc;
    else if (req.addr == ADDR_SAG_LVL)    rd_mux = rv_sag_lvl;
    else if (req.addr == ADDR_IPK_LVL)    rd_mux = rv_ipk_lvl;
    else if (req.addr == ADDR_VPK_LVL)    rd_mux = rv_vpk_lvl;
    else if (req.addr == ADDR_IPK_REC ||
             req.addr == ADDR_IPK_RC)     rd_mux = ipk_rec_r;
    else if (req.addr == ADDR_VPK_REC ||
             req.addr == ADDR_VPK_RC)     rd_mux = vpk_rec_r;
    else if (req.addr == ADDR_IRQ_EN_HI)  rd_mux = rv_irq_en;
    else if (req.addr == ADDR_IRQ_ST_HI)  rd_mux = rv_irq_st;
    else if (req.addr == ADDR_PSM_EN)     rd_mux = rv_psm_en;
    else if (req.addr == ADDR_PSM_FLAGS)  rd_mux = rv_psm_fl;
    else                                  rd_mux = 24'h000000;
  end

  // Integrator follows a mode-one write at the same edge as the register
  wire integ_nxt = wr_measurement_mode_one ? req.wdata[BIT_INTEG_EN]
                            : mode_one_r[BIT_INTEG_EN];
  // Interrupt lines follow the flags already held
  wire ade_irq_nxt = |(irq_st_r & irq_en_r);
  wire psm_irq_nxt = psm_fl_r[BIT_SAG] & psm_en_r[BIT_SAG];
  // Read data stands one cycle after the strobe, zero otherwise
  wire [23:0] rdata_nxt = req.rd ? rd_mux : 24'h000000;

  // ---------------------------------------------------------------
  // Output flip-flops
  // ---------------------------------------------------------------
  // Read data register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 24'h000000;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // Level and pulse outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      integ_en <= 1'b0;
      ade_irq  <= 1'b0;
      psm_irq  <= 1'b0;
      zx_pulse <= 1'b0;
    end else begin
      integ_en <= integ_nxt;
      ade_irq  <= ade_irq_nxt;
      psm_irq  <= psm_irq_nxt;
      zx_pulse <= zx_evt;
    end
  end

endmodule // power_quality_monitor

`default_nettype wire

// ### core/pqm_pkg.sv
/*
  Constants, register map and carrier types for the power-quality monitor.
  Assumes a 125 MHz master clock and a plain register port.
*/
package pqm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LINE_PERIOD_OR_FREQUENCY   = 8'h0a;
  localparam logic [7:0] ADDR_MODE_ONE   = 8'h0b;
  localparam logic [7:0] ADDR_MODE_TWO   = 8'h0c;
  localparam logic [7:0] ADDR_ZX_TIMEOUT = 8'h11;
  localparam logic [7:0] ADDR_SAG_CYC    = 8'h13;
  localparam logic [7:0] ADDR_SAG_LVL    = 8'h14;
  localparam logic [7:0] ADDR_IPK_LVL    = 8'h15;
  localparam logic [7:0] ADDR_VPK_LVL    = 8'h16;
  localparam logic [7:0] ADDR_IPK_REC    = 8'h17;
  localparam logic [7:0] ADDR_IPK_RC     = 8'h18;
  localparam logic [7:0] ADDR_VPK_REC    = 8'h19;
  localparam logic [7:0] ADDR_VPK_RC     = 8'h1a;
  localparam logic [7:0] ADDR_IRQ_EN_HI  = 8'hdb;
  localparam logic [7:0] ADDR_IRQ_ST_HI  = 8'hde;
  localparam logic [7:0] ADDR_PSM_EN     = 8'hec;
  localparam logic [7:0] ADDR_PSM_FLAGS  = 8'hf8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_INTEG_EN  = 5;  // mode one
  localparam int BIT_LPF_BYP   = 6;  // mode one, filter bypass
  localparam int BIT_FREQ_SEL  = 1;  // mode two
  localparam int BIT_ZX        = 0;  // upper status / enable
  localparam int BIT_CROSSING_TIMEOUT_FLAG      = 1;
  localparam int BIT_PKV       = 3;
  localparam int BIT_PKI       = 4;
  localparam int BIT_SAG       = 5;  // supply management

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [11:0] ZX_TIMEOUT_RST = 12'hfff;
  localparam logic [7:0]  SAG_CYC_RST    = 8'hff;
  localparam logic [15:0] SAG_LVL_RST    = 16'h0000;
  localparam logic [15:0] PK_LVL_RST     = 16'hffff;
  localparam int CROSSING_TIMEOUT_FLAG_DIV   = 160;  // clocks per timeout step
  localparam int PER_DIV    = 10;   // clocks per period LSB
  localparam int LPF_SHIFT  = 12;   // single-pole filter shift

  // Sample carrier from the data path
  typedef struct packed {
    logic        valid;
    logic [23:0] volt;  // signed voltage sample
    logic [23:0] curr;  // signed current sample
  } sample_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// ### dv/line_source.sv
/* Stand-in for the data path: square wave or steady level samples.
   Driven by tb; a sample every fourth clock while run is high. */
`timescale 1ns/100ps
`default_nettype none
module line_source
  import pqm_pkg::*;
#(parameter int HALF = 100) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic        wave,
  input  wire logic [23:0] amp,
  input  wire logic [23:0] curr,
  output var  sample_t     smp
);
  logic [7:0] cnt_r;
  logic       neg_r;
  initial smp = '0;
  // Half-period counter, polarity, then samples; idle data keeps toggling
  always @(posedge clk) begin
    cnt_r <= (!rstn || cnt_r == 8'(HALF - 1)) ? 8'h00 : cnt_r + 8'h01;
    neg_r <= rstn && (neg_r ^ (cnt_r == 8'(HALF - 1)));
    if (rstn && run && cnt_r[1:0] == 2'h0)
      smp <= '{1'b1, (wave && neg_r) ? 24'h0 - amp : amp, curr};
    else
      smp <= '{1'b0, ~smp.volt, ~smp.curr};
  end
endmodule // line_source
`default_nettype wire

// ### dv/pqm_assertions.sv
/* Port checker for the power-quality monitor.
   Bound from tb; shadows enables and peak levels written over the port. */
`timescale 1ns/100ps
`default_nettype none
module pqm_assertions
  import pqm_pkg::*;
#(parameter int unsigned FREQ_NUM = 32'd6553600) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire sample_t     smp,
  input wire reg_req_t    req,
  input wire logic [23:0] rdata,
  input wire logic        integ_en,
  input wire logic        ade_irq,
  input wire logic        psm_irq,
  input wire logic        zx_pulse
);
  logic [7:0]  en_r, psm_en_r;
  logic [15:0] vlvl_r, ilvl_r;
  logic [23:0] vmag, imag;
  logic        wr_m1, voltage_peak_flag, current_peak_flag;
  // Magnitudes and trigger terms
  assign vmag  = smp.volt[23] ? 24'h0 - smp.volt : smp.volt;
  assign imag  = smp.curr[23] ? 24'h0 - smp.curr : smp.curr;
  assign wr_m1 = req.wr && req.addr == ADDR_MODE_ONE;
  assign voltage_peak_flag   = smp.valid && vmag[23:8] > vlvl_r && en_r[BIT_PKV];
  assign current_peak_flag   = smp.valid && imag[23:8] > ilvl_r && en_r[BIT_PKI];
  // Shadows of written enables and levels
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_r     <= 8'h00;
      psm_en_r <= 8'h00;
      vlvl_r   <= PK_LVL_RST;
      ilvl_r   <= PK_LVL_RST;
    end else if (req.wr) begin
      case (req.addr)
        ADDR_IRQ_EN_HI: en_r     <= req.wdata[7:0];
        ADDR_PSM_EN:    psm_en_r <= req.wdata[7:0];
        ADDR_VPK_LVL:   vlvl_r   <= req.wdata[15:0];
        ADDR_IPK_LVL:   ilvl_r   <= req.wdata[15:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_integ; wr_m1 |=> integ_en == $past(req.wdata[5]); endproperty
  a_integ: assert property (p_integ) else $error("integ_en wrong");
  property p_ihold; !wr_m1 |=> $stable(integ_en); endproperty
  a_ihold: assert property (p_ihold) else $error("integ_en moved");
  property p_idle; !req.rd |=> rdata == 24'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_zx; zx_pulse && en_r[BIT_ZX] |-> ##[1:2] ade_irq; endproperty
  a_zx: assert property (p_zx) else $error("no crossing irq");
  property p_vpk; voltage_peak_flag |-> ##[1:2] ade_irq; endproperty
  a_vpk: assert property (p_vpk) else $error("no voltage peak irq");
  property p_ipk; current_peak_flag |-> ##[1:2] ade_irq; endproperty
  a_ipk: assert property (p_ipk) else $error("no current peak irq");
  property p_mask; en_r == 8'h00 [*2] |-> !ade_irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq seen");
  property p_psm; !psm_en_r[BIT_SAG] [*2] |-> !psm_irq; endproperty
  a_psm: assert property (p_psm) else $error("masked sag irq");
endmodule // pqm_assertions
`default_nettype wire

// ### dv/tb.sv
/* Self-checking bench for the power-quality monitor.
   Needs pqm_pkg, line_source and pqm_assertions compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb
  import pqm_pkg::*;
;
  localparam int HALF = 100;
  localparam int FNUM = 20000;
  localparam int PCNT = 2 * HALF / PER_DIV;
  localparam logic [23:0] ALL = 24'hffffff;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        run = 1'b0;
  logic        wave = 1'b0;
  logic [23:0] amp = 24'h0;
  logic [23:0] curr = 24'h0;
  logic [23:0] d, rdata;
  logic        integ_en, ade_irq, psm_irq, zx_pulse;
  reg_req_t    req = '0;
  sample_t     smp;
  int          mismatches = 0;
  int          tests_run = 0;
  int          zx_seen = 0;
  // Clock, data path model and the design
  always #4 clk = ~clk;
  // Count crossing pulses seen at the design's output
  always @(posedge clk)
    if (zx_pulse) zx_seen++;
  line_source #(.HALF(HALF)) line_source_i (.clk(clk), .rstn(rstn),
    .run(run), .wave(wave), .amp(amp), .curr(curr), .smp(smp));
  power_quality_monitor #(.FREQ_NUM(FNUM)) power_quality_monitor_i (
    .clk(clk), .rstn(rstn), .smp(smp), .req(req), .rdata(rdata),
    .integ_en(integ_en), .ade_irq(ade_irq), .psm_irq(psm_irq),
    .zx_pulse(zx_pulse));
  // Comparison, verdict and register port tasks
  task automatic chk(input string n, input logic [23:0] got, e);
    tests_run++;
    if (got !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{a, 24'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rdck(input logic [7:0] a, input logic [23:0] m, e);
    rd(a);
    chk($sformatf("reg_%h", a), d & m, e);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    d = 24'h0;
    for (int i = 0; i < 600 && d[b] !== 1'b1; i++)
      rd(a);
    if (d[b] !== 1'b1) begin
      mismatches++;
      $display("ERROR wait on reg_%h ran out", a);
      finish_test();
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdck(ADDR_ZX_TIMEOUT, ALL, 24'h000fff);
    rdck(ADDR_LINE_PERIOD_OR_FREQUENCY, ALL, 24'h0);
    rdck(ADDR_VPK_REC, ALL, 24'h0);
    rdck(8'h00, ALL, 24'h0);
    chk("integ_en", {23'h0, integ_en}, 24'h0);
    wr(ADDR_MODE_ONE, 24'h000060); // Filter bypassed
    chk("integ_en", {23'h0, integ_en}, 24'h1);
    wr(ADDR_ZX_TIMEOUT, 24'h000002);
    rdck(ADDR_ZX_TIMEOUT, ALL, 24'h000002);
    wr(ADDR_IPK_REC, 24'h000055);
    rdck(ADDR_IPK_REC, ALL, 24'h0);
    $display("test registers done");
    wr(ADDR_IRQ_EN_HI, 24'h000003);
    amp <= 24'h040000;
    wave <= 1'b1;
    run <= 1'b1;
    repeat (6 * HALF) @(posedge clk);
    rd(ADDR_LINE_PERIOD_OR_FREQUENCY);
    chk("period", {23'h0, int'(d) inside {[PCNT-1:PCNT+1]}}, 24'h1);
    rdck(ADDR_IRQ_ST_HI, 24'h000001, 24'h000001);
    chk("ade_irq", {23'h0, ade_irq}, 24'h1);
    wr(ADDR_MODE_TWO, 24'h000002);
    zx_seen = 0;
    repeat (4 * HALF) @(posedge clk);
    rd(ADDR_LINE_PERIOD_OR_FREQUENCY);
    chk("zx_pulse", {23'h0, zx_seen inside {[4:5]}}, 24'h1);
    chk("freq", {23'h0, int'(d) inside {[FNUM/(PCNT+1):FNUM/(PCNT-1)]}},
        24'h1);
    $display("test period done");
    run <= 1'b0;
    wr(ADDR_IRQ_ST_HI, 24'h0);
    rdck(ADDR_IRQ_ST_HI, 24'h000002, 24'h0);
    poll(ADDR_IRQ_ST_HI, BIT_CROSSING_TIMEOUT_FLAG);
    wr(ADDR_IRQ_EN_HI, 24'h0);
    repeat (2) @(posedge clk);
    chk("ade_irq", {23'h0, ade_irq}, 24'h0);
    $display("test timeout done");
    wr(ADDR_VPK_LVL, 24'h000100);
    wr(ADDR_IPK_LVL, 24'h000100);
    wr(ADDR_IRQ_EN_HI, 24'h000018);
    wave <= 1'b0;
    amp <= 24'hfedcbb;
    curr <= 24'h020000;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    rdck(ADDR_IRQ_ST_HI, 24'h000018, 24'h000018);
    chk("ade_irq", {23'h0, ade_irq}, 24'h1);
    rdck(ADDR_VPK_RC, ALL, 24'h040000);
    repeat (20) @(posedge clk);
    rdck(ADDR_VPK_REC, ALL, 24'h012345);
    run <= 1'b0;
    @(posedge clk);
    req <= '{ADDR_IPK_RC, 24'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '{ADDR_IPK_REC, 24'h0, 1'b0, 1'b1};
    @(negedge clk);
    chk("ipk_rc", rdata, 24'h020000);
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk("ipk_rec", rdata, 24'h0);
    $display("test peaks done");
    wr(ADDR_SAG_CYC, 24'h000003);
    wr(ADDR_SAG_LVL, 24'h000200);
    wr(ADDR_PSM_EN, 24'h000020);
    wave <= 1'b1;
    amp <= 24'h010000;
    run <= 1'b1;
    rdck(ADDR_PSM_FLAGS, 24'h000020, 24'h0);
    poll(ADDR_PSM_FLAGS, BIT_SAG);
    chk("psm_irq", {23'h0, psm_irq}, 24'h1);
    wr(ADDR_PSM_EN, 24'h0);
    repeat (2) @(posedge clk);
    chk("psm_irq", {23'h0, psm_irq}, 24'h0);
    $display("test sag done");
    finish_test();
  end
endmodule // tb
bind power_quality_monitor pqm_assertions #(.FREQ_NUM(FREQ_NUM))
  pqm_assertions_i (.clk(clk), .rstn(rstn), .smp(smp), .req(req),
  .rdata(rdata), .integ_en(integ_en), .ade_irq(ade_irq),
  .psm_irq(psm_irq), .zx_pulse(zx_pulse));
`default_nettype wire
